// [shared/sig_detect_pkg.sv]
package sig_detect_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL    = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_THRESH  = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_STRENGTH = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h010;
  // Control field positions
  localparam int CTRL_AVG_LSB   = 0;
  localparam int CTRL_SEL_LSB   = 4;
  localparam int CTRL_WIN_LSB   = 8;
  localparam int CTRL_MUTE_BIT  = 12;
  localparam int CTRL_IRQSRC_BIT = 13;
  localparam int CTRL_EXTSRC_BIT = 14;
  localparam int CTRL_DIRECT_BIT = 15;
  // Reset values
  localparam logic [2:0] AVG_ORDER_RST = 3'h0;
  localparam logic [1:0] REPORT_SEL_RST = 2'h0;
  localparam logic [1:0] JUMP_SEL_RST  = 2'h2;
  localparam logic [7:0] THRESH_RST    = 8'hFF;
  localparam logic [1:0] IRQ_MASK_RST  = 2'h0;
  // Interrupt status bits
  localparam int IRQ_VALID_BIT = 0;
  localparam int IRQ_JUMP_BIT  = 1;
  localparam int IRQ_W         = 2;
  // Report select codes
  localparam logic [1:0] SEL_LIVE     = 2'h0;
  localparam logic [1:0] SEL_LATCH_RX = 2'h1;
  localparam logic [1:0] SEL_LATCH_PKT = 2'h2;
  localparam logic [1:0] SEL_LATCH_SYNC = 2'h3;
  // Strength-to-dBm conversion offset
  localparam logic [7:0] DBM_OFFSET = 8'h80;
  // Jump counts per window select
  localparam logic [3:0] JUMPS_0 = 4'h1;
  localparam logic [3:0] JUMPS_1 = 4'h2;
  localparam logic [3:0] JUMPS_2 = 4'h4;
  localparam logic [3:0] JUMPS_3 = 4'h8;
  localparam int SNR_MIN_DB = 7;
endpackage

// [verilog/strength_avg_filter.sv]
`timescale 1ns/1ns
module strength_avg_filter
  import sig_detect_pkg::*;
#(
  parameter int W = 8,
  parameter int ACC_W = 16
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Samples
  input  wire logic         sample_valid,
  input  wire logic [W-1:0] sample_code,
  input  wire logic [2:0]   order,
  // Result
  output logic [W-1:0]      avg_code,
  output logic              avg_valid
);
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic [ACC_W-1:0] mean;

  // Exponential average with weight 2^-order
  always_comb begin
    mean = acc_reg >> order;
    acc_next = acc_reg - mean + ACC_W'(sample_code);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg   <= '0;
      avg_code  <= '0;
      avg_valid <= 1'b0;
    end else begin
      avg_valid <= sample_valid;
      if (sample_valid) begin
        if (order == 3'h0) begin
          acc_reg  <= ACC_W'(sample_code);
          avg_code <= sample_code;
        end else begin
          acc_reg  <= acc_next;
          avg_code <= W'(acc_next >> order);
        end
      end
    end
  end
endmodule

// [verilog/rx_channel_signal_detect.sv]
// Summary of operation
// - Strength samples pass an averaging filter whose order is a 3-bit field.
// - The filtered code is converted to dBm; code and dBm both read back.
// - A 2-bit select picks the live strength or one latched in a rx state.
// - Output is 1 only when live strength is strictly above the threshold.
// - The threshold result can feed the valid irq and the rx extension.
// - Each 0-to-1 or 1-to-0 change of the demodulated stream is one jump.
// - A 2-bit field sets how many jumps qualify the signal as wanted.
// - Jump result is 1 only with jumps, valid deviation and SNR above 7 dB.
// - The jump result can feed the valid irq and the rx extension.
// - In direct mode with mute set, data is held low while no signal found.
`timescale 1ns/1ns
module rx_channel_signal_detect
  import sig_detect_pkg::*;
(
  // APB
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [sig_detect_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [sig_detect_pkg::DATA_W-1:0]   pwdata,
  output logic      [sig_detect_pkg::DATA_W-1:0]   prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // Strength samples
  input  wire logic                                sample_valid,
  input  wire logic [7:0]                          sample_code,
  // Receive state latch strobes
  input  wire logic                                rx_enter,
  input  wire logic                                pkt_detect,
  input  wire logic                                sync_detect,
  // Demodulator
  input  wire logic                                fsk_mode,
  input  wire logic                                demod_valid,
  input  wire logic                                demod_data,
  input  wire logic                                dev_valid,
  input  wire logic [7:0]                          snr_db,
  // Outputs
  output logic                                     data_out,
  output logic                                     strength_above,
  output logic                                     jump_detect,
  output logic                                     rx_extend,
  output logic                                     irq
);
  import sig_detect_pkg::*;

  logic [2:0] strength_avg_order;
  logic [1:0] strength_report_select;
  logic [1:0] jump_count_select;
  logic [7:0] strength_trigger_threshold;
  logic       mute_reg;
  logic       irq_src_reg;
  logic       ext_src_reg;
  logic       direct_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [7:0] strength_raw_code;
  logic       avg_valid;
  logic [7:0] live_code;
  logic [7:0] latch_code_reg;
  logic [7:0] report_code;
  logic [7:0] strength_dbm_value;
  logic [3:0] jump_cnt_reg;
  logic [3:0] jump_need;
  logic       last_bit_reg;
  logic       have_bit_reg;
  logic       jump_ok;
  logic       jump_prev_reg;
  logic       valid_prev_reg;
  logic       valid_src;
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign addr_ok = (paddr == OFF_CTRL) || (paddr == OFF_THRESH) ||
                   (paddr == OFF_STRENGTH) || (paddr == OFF_IRQ_STAT) ||
                   (paddr == OFF_IRQ_MASK);
  assign pslverr = psel && penable && !addr_ok;

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strength_avg_order         <= AVG_ORDER_RST;
      strength_report_select     <= REPORT_SEL_RST;
      jump_count_select          <= JUMP_SEL_RST;
      strength_trigger_threshold <= THRESH_RST;
      mute_reg                   <= 1'b0;
      irq_src_reg                <= 1'b0;
      ext_src_reg                <= 1'b0;
      direct_reg                 <= 1'b0;
      irq_mask_reg               <= IRQ_MASK_RST;
    end else if (wr_en) begin
      case (paddr)
        OFF_CTRL: begin
          strength_avg_order     <= pwdata[CTRL_AVG_LSB +: 3];
          strength_report_select <= pwdata[CTRL_SEL_LSB +: 2];
          jump_count_select      <= pwdata[CTRL_WIN_LSB +: 2];
          mute_reg               <= pwdata[CTRL_MUTE_BIT];
          irq_src_reg            <= pwdata[CTRL_IRQSRC_BIT];
          ext_src_reg            <= pwdata[CTRL_EXTSRC_BIT];
          direct_reg             <= pwdata[CTRL_DIRECT_BIT];
        end
        OFF_THRESH: strength_trigger_threshold <= pwdata[7:0];
        OFF_IRQ_MASK: irq_mask_reg <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  strength_avg_filter #(
    .W     (8),
    .ACC_W (16)
  ) u_filter (
    .pclk         (pclk),
    .presetn      (presetn),
    .sample_valid (sample_valid),
    .sample_code  (sample_code),
    .order        (strength_avg_order),
    .avg_code     (live_code),
    .avg_valid    (avg_valid)
  );

  // Latched value captured on the selected receive event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_code_reg <= '0;
    end else begin
      case (strength_report_select)
        SEL_LATCH_RX:   if (rx_enter) latch_code_reg <= live_code;
        SEL_LATCH_PKT:  if (pkt_detect) latch_code_reg <= live_code;
        SEL_LATCH_SYNC: if (sync_detect) latch_code_reg <= live_code;
        default:        latch_code_reg <= live_code;
      endcase
    end
  end

  assign report_code = (strength_report_select == SEL_LIVE) ?
                       live_code : latch_code_reg;

  // Code to dBm: signed value, code minus offset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strength_raw_code  <= '0;
      strength_dbm_value <= '0;
    end else begin
      strength_raw_code  <= report_code;
      strength_dbm_value <= report_code - DBM_OFFSET;
    end
  end

  // Threshold compare on the live value, strict
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strength_above <= 1'b0;
    end else begin
      strength_above <= live_code > strength_trigger_threshold;
    end
  end

  always_comb begin
    case (jump_count_select)
      2'h0:    jump_need = JUMPS_0;
      2'h1:    jump_need = JUMPS_1;
      2'h2:    jump_need = JUMPS_2;
      default: jump_need = JUMPS_3;
    endcase
  end

  // Phase jump counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jump_cnt_reg <= '0;
      last_bit_reg <= 1'b0;
      have_bit_reg <= 1'b0;
    end else if (!fsk_mode) begin
      jump_cnt_reg <= '0;
      have_bit_reg <= 1'b0;
    end else if (demod_valid) begin
      last_bit_reg <= demod_data;
      have_bit_reg <= 1'b1;
      if (have_bit_reg && (demod_data != last_bit_reg)) begin
        if (jump_cnt_reg < JUMPS_3) begin
          jump_cnt_reg <= jump_cnt_reg + 4'h1;
        end
      end
    end
  end

  assign jump_ok = fsk_mode && (jump_cnt_reg >= jump_need) && dev_valid &&
                   (snr_db > 8'(SNR_MIN_DB));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jump_detect <= 1'b0;
    end else begin
      jump_detect <= jump_ok;
    end
  end

  // Source selection
  assign valid_src = irq_src_reg ? jump_detect : strength_above;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_extend <= 1'b0;
    end else begin
      rx_extend <= ext_src_reg ? jump_detect : strength_above;
    end
  end

  // Mute of direct-mode data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out <= 1'b0;
    end else begin
      data_out <= (direct_reg && mute_reg && !jump_detect) ?
                  1'b0 : demod_data;
    end
  end

  // Sticky interrupt status on rising edges, cleared by read; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg   <= '0;
      valid_prev_reg <= 1'b0;
      jump_prev_reg  <= 1'b0;
    end else begin
      valid_prev_reg <= valid_src;
      jump_prev_reg  <= jump_detect;
      irq_stat_reg <= ((rd_en && paddr == OFF_IRQ_STAT) ? '0 : irq_stat_reg)
                    | {jump_detect && !jump_prev_reg,
                       valid_src && !valid_prev_reg};
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  always_comb begin
    prdata = '0;
    if (rd_en) begin
      case (paddr)
        OFF_CTRL: begin
          prdata[CTRL_AVG_LSB +: 3] = strength_avg_order;
          prdata[CTRL_SEL_LSB +: 2] = strength_report_select;
          prdata[CTRL_WIN_LSB +: 2] = jump_count_select;
          prdata[CTRL_MUTE_BIT]     = mute_reg;
          prdata[CTRL_IRQSRC_BIT]   = irq_src_reg;
          prdata[CTRL_EXTSRC_BIT]   = ext_src_reg;
          prdata[CTRL_DIRECT_BIT]   = direct_reg;
        end
        OFF_THRESH:   prdata[7:0] = strength_trigger_threshold;
        OFF_STRENGTH: prdata[15:0] = {strength_dbm_value, strength_raw_code};
        OFF_IRQ_STAT: prdata[IRQ_W-1:0] = irq_stat_reg;
        OFF_IRQ_MASK: prdata[IRQ_W-1:0] = irq_mask_reg;
        default:      prdata = '0;
      endcase
    end
  end

  property p_above_strict;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> strength_above == ($past(live_code) >
                                  $past(strength_trigger_threshold));
  endproperty
  a_above_strict: assert property (p_above_strict)
    else $error("threshold compare wrong");

  property p_jump_needs_snr;
    @(posedge pclk) disable iff (!presetn)
      jump_detect |-> $past(snr_db) > 8'(SNR_MIN_DB) && $past(dev_valid);
  endproperty
  a_jump_needs_snr: assert property (p_jump_needs_snr)
    else $error("jump detect without snr or deviation");

  property p_jump_needs_count;
    @(posedge pclk) disable iff (!presetn)
      jump_detect |-> $past(jump_cnt_reg) >= $past(jump_need);
  endproperty
  a_jump_needs_count: assert property (p_jump_needs_count)
    else $error("jump detect before enough jumps");

  property p_jump_counted;
    @(posedge pclk) disable iff (!presetn)
      fsk_mode && demod_valid && have_bit_reg &&
      demod_data != last_bit_reg && jump_cnt_reg < JUMPS_3
      |=> jump_cnt_reg == $past(jump_cnt_reg) + 4'h1;
  endproperty
  a_jump_counted: assert property (p_jump_counted)
    else $error("phase jump not counted");

  property p_mute;
    @(posedge pclk) disable iff (!presetn)
      direct_reg && mute_reg && !jump_detect |=> !data_out;
  endproperty
  a_mute: assert property (p_mute)
    else $error("muted data passed");

  property p_dbm;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> strength_dbm_value == strength_raw_code - DBM_OFFSET;
  endproperty
  a_dbm: assert property (p_dbm)
    else $error("dbm conversion wrong");

  property p_live_report;
    @(posedge pclk) disable iff (!presetn)
      strength_report_select == SEL_LIVE |=>
        strength_raw_code == $past(live_code);
  endproperty
  a_live_report: assert property (p_live_report)
    else $error("live report wrong");

  property p_extend_src;
    @(posedge pclk) disable iff (!presetn)
      ext_src_reg && $stable(ext_src_reg) |=>
        rx_extend == $past(jump_detect);
  endproperty
  a_extend_src: assert property (p_extend_src)
    else $error("extension source wrong");

  property p_irq_src;
    @(posedge pclk) disable iff (!presetn)
      !irq_src_reg && strength_above && !valid_prev_reg |=>
        irq_stat_reg[IRQ_VALID_BIT];
  endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("valid irq not set");
endmodule

// [bench/rx_channel_signal_detect_tb_top.sv]
`timescale 1ns/1ns
module rx_channel_signal_detect_tb_top;
  import sig_detect_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, er;
  logic        sample_valid = 0, rx_enter = 0, pkt_detect = 0;
  logic        sync_detect = 0, fsk_mode = 0, demod_valid = 0;
  logic        demod_data = 0, dev_valid = 0;
  logic [7:0]  sample_code = '0, snr_db = '0;
  logic        data_out, strength_above, jump_detect, rx_extend, irq;
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #10 pclk = ~pclk;

  rx_channel_signal_detect u_rx_channel_signal_detect (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .sample_code(sample_code), .rx_enter(rx_enter),
    .pkt_detect(pkt_detect), .sync_detect(sync_detect),
    .fsk_mode(fsk_mode), .demod_valid(demod_valid),
    .demod_data(demod_data), .dev_valid(dev_valid), .snr_db(snr_db),
    .data_out(data_out), .strength_above(strength_above),
    .jump_detect(jump_detect), .rx_extend(rx_extend), .irq(irq)
  );

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Setup then access phase; release after pready seen high or after 50 edges
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    // One idle edge so a following call never re-drives psel at once
    @(posedge pclk);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic smp(input logic [7:0] c);
    sample_valid <= 1;
    sample_code <= c;
    cyc(1);
    sample_valid <= 0;
    cyc(3);
  endtask

  task automatic sym(input logic b);
    demod_valid <= 1;
    demod_data <= b;
    cyc(1);
    demod_valid <= 0;
    cyc(3);
  endtask

  // Clear the jump counter and leave the last symbol at 0
  task automatic clr_jumps();
    fsk_mode <= 0;
    cyc(1);
    fsk_mode <= 1;
    sym(0);
  endtask

  task automatic t_reset();
    apb(0, OFF_CTRL, 0);
    chk("ctrl", 32'h0000_0200, rd);
    apb(0, OFF_THRESH, 0);
    chk("thresh", 32'h0000_00FF, rd);
    apb(0, OFF_IRQ_MASK, 0);
    chk("mask", 32'h0000_0000, rd);
    apb(0, 12'h020, 0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    $display("test reset done");
  endtask

  task automatic t_strength();
    apb(1, OFF_THRESH, 32'h0000_0050);
    apb(1, OFF_CTRL, 32'h0000_0000);
    smp(8'h50);
    chk("above eq", 32'h0, {31'h0, strength_above});
    apb(0, OFF_STRENGTH, 0);
    chk("strength", 32'h0000_D050, rd);
    smp(8'h51);
    chk("above gt", 32'h1, {31'h0, strength_above});
    chk("ext strength", 32'h1, {31'h0, rx_extend});
    $display("test strength done");
  endtask

  task automatic t_latch();
    apb(1, OFF_CTRL, 32'h0000_0010);
    smp(8'h60);
    rx_enter <= 1;
    cyc(1);
    rx_enter <= 0;
    cyc(2);
    smp(8'h20);
    apb(0, OFF_STRENGTH, 0);
    chk("latched raw", 32'h60, {24'h0, rd[7:0]});
    chk("above live", 32'h0, {31'h0, strength_above});
    apb(1, OFF_CTRL, 32'h0000_0020);
    smp(8'h44);
    pkt_detect <= 1;
    cyc(1);
    pkt_detect <= 0;
    cyc(2);
    smp(8'h20);
    apb(0, OFF_STRENGTH, 0);
    chk("pkt raw", 32'h44, {24'h0, rd[7:0]});
    apb(1, OFF_CTRL, 32'h0000_0030);
    smp(8'h33);
    sync_detect <= 1;
    cyc(1);
    sync_detect <= 0;
    cyc(2);
    smp(8'h20);
    apb(0, OFF_STRENGTH, 0);
    chk("sync raw", 32'h33, {24'h0, rd[7:0]});
    apb(1, OFF_CTRL, 32'h0000_0000);
    apb(0, OFF_STRENGTH, 0);
    chk("live raw", 32'h20, {24'h0, rd[7:0]});
    $display("test latch done");
  endtask

  // Order 1 halves the step toward each new sample, starting from zero
  task automatic t_filter();
    smp(8'h00);
    apb(1, OFF_CTRL, 32'h0000_0001);
    smp(8'h80);
    apb(0, OFF_STRENGTH, 0);
    chk("avg one", 32'h40, {24'h0, rd[7:0]});
    smp(8'h80);
    apb(0, OFF_STRENGTH, 0);
    chk("avg two", 32'h60, {24'h0, rd[7:0]});
    apb(1, OFF_CTRL, 32'h0000_0000);
    smp(8'h20);
    $display("test filter done");
  endtask

  task automatic t_jumps();
    int need;
    dev_valid <= 1;
    snr_db <= 8'h08;
    for (int s = 0; s < 4; s++) begin
      need = 1 << s;
      apb(1, OFF_CTRL, 32'h4000 | (s << 8));
      clr_jumps();
      for (int j = 0; j < need - 1; j++) sym(~j[0]);
      chk("jump early", 32'h0, {31'h0, jump_detect});
      sym(need[0] ? 1'b1 : 1'b0);
      chk("jump enough", 32'h1, {31'h0, jump_detect});
      chk("ext jump", 32'h1, {31'h0, rx_extend});
    end
    clr_jumps();
    $display("test jumps done");
  endtask

  task automatic t_quality();
    apb(1, OFF_CTRL, 32'h0000_4000);
    snr_db <= 8'h07;
    clr_jumps();
    sym(1);
    chk("snr seven", 32'h0, {31'h0, jump_detect});
    snr_db <= 8'h08;
    dev_valid <= 0;
    cyc(3);
    chk("dev bad", 32'h0, {31'h0, jump_detect});
    dev_valid <= 1;
    cyc(3);
    chk("all good", 32'h1, {31'h0, jump_detect});
    $display("test quality done");
  endtask

  task automatic t_mute();
    apb(1, OFF_CTRL, 32'h0000_9200);
    clr_jumps();
    demod_data <= 1;
    cyc(3);
    chk("muted", 32'h0, {31'h0, data_out});
    apb(1, OFF_CTRL, 32'h0000_8200);
    cyc(2);
    chk("unmuted", 32'h1, {31'h0, data_out});
    demod_data <= 0;
    cyc(2);
    $display("test mute done");
  endtask

  task automatic t_irq();
    apb(1, OFF_IRQ_MASK, 32'h2);
    apb(1, OFF_CTRL, 32'h0000_2000);
    apb(0, OFF_IRQ_STAT, 0);
    cyc(1);
    chk("irq quiet", 32'h0, {31'h0, irq});
    clr_jumps();
    sym(1);
    chk("irq set", 32'h1, {31'h0, irq});
    apb(0, OFF_IRQ_STAT, 0);
    chk("stat", 32'h3, rd);
    cyc(1);
    chk("irq clear", 32'h0, {31'h0, irq});
    apb(1, OFF_IRQ_MASK, 32'h0);
    clr_jumps();
    sym(1);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(0, OFF_IRQ_STAT, 0);
    chk("stat masked", 32'h3, rd);
    $display("test irq done");
  endtask

  initial begin
    cyc(20);
    presetn <= 1;
    cyc(1);
    t_reset();
    t_strength();
    t_latch();
    t_filter();
    t_jumps();
    t_quality();
    t_mute();
    t_irq();
    report_and_stop();
  end

  // Tests need about 310 cycles; give ample margin
  initial begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
endmodule
